// ===== irq_ctrl_pkg.sv
package irq_ctrl_pkg;

  // -------------------------------------------------------------------------
  // sources, in natural order (index 0 wins ties)
  // -------------------------------------------------------------------------
  localparam int unsigned NUM_SRC         = 14;
  localparam int unsigned SRC_PFAIL       = 0;
  localparam int unsigned SRC_EXT0        = 1;
  localparam int unsigned SRC_TMR0        = 2;
  localparam int unsigned SRC_EXT1        = 3;
  localparam int unsigned SRC_TMR1        = 4;
  localparam int unsigned SRC_UART0       = 5;
  localparam int unsigned SRC_TMR2        = 6;
  localparam int unsigned SRC_UART1       = 7;
  localparam int unsigned SRC_EXT2        = 8;
  localparam int unsigned SRC_EXT3        = 9;
  localparam int unsigned SRC_EXT4        = 10;
  localparam int unsigned SRC_EXT5        = 11;
  localparam int unsigned SRC_WDOG        = 12;
  localparam int unsigned SRC_RTC         = 13;

  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned CLKS_PER_MCYC   = 4;
  localparam int unsigned FORCED_LONG_CALL_MCYC      = 4;
  localparam int unsigned MIN_RESP_MCYC   = 5;
  localparam int unsigned MAX_RESP_MCYC   = 13;

  // -------------------------------------------------------------------------
  // register word offsets (byte addresses)
  // -------------------------------------------------------------------------
  localparam logic [7:0] OFS_FLAG_SET     = 8'h00;
  localparam logic [7:0] OFS_FLAG_CLR     = 8'h04;
  localparam logic [7:0] OFS_ENABLE       = 8'h08;
  localparam logic [7:0] OFS_PRIORITY     = 8'h0C;
  localparam logic [7:0] OFS_CONFIG       = 8'h10;
  localparam logic [7:0] OFS_STATUS       = 8'h14;

  // config bits
  localparam int unsigned CFG_GLOBAL_EN   = 0;
  localparam int unsigned CFG_PFAIL_EN    = 1;
  localparam int unsigned CFG_EXT0_EDGE   = 2;
  localparam int unsigned CFG_EXT1_EDGE   = 3;

  // reset values
  localparam logic [13:0] ENABLE_RST      = 14'h0000;
  localparam logic [13:0] PRIORITY_RST    = 14'h0000;
  localparam logic [3:0]  CONFIG_RST      = 4'h0;

  // vector base and spacing
  localparam logic [15:0] VEC_BASE        = 16'h0003;
  localparam logic [15:0] VEC_STEP        = 16'h0008;

  typedef enum logic [1:0] {
    LVL_LOW,
    LVL_HIGH,
    LVL_TOP
  } level_e;

endpackage : irq_ctrl_pkg

// ===== interrupt_priority_controller.sv
// Functional notes
// - uart has rx/tx flags, untouched by service
// - uart flags set only on word done
// - rtc alarm lowest, wakes from stop
// - power-fail top, own enable only
// - power-fail flag follows warning level
// - software-set flag acts like hardware request
// - clear cancels pending, not active service
// - rtc alarm flag not software settable
// - three levels, others programmable, reset low
// - only strictly higher level preempts
// - natural order breaks simultaneous ties
// - sample per machine cycle, call next
// - level external flags track pin
// - call withheld by busy, midinstr, return_from_interrupt, writes
// - minimum response five machine cycles
// - worst response thirteen machine cycles
// - hardware set beats software clear same cycle; software set beats call auto-clear
// - deferred request uses newly written values
// - vector chosen combinationally in one cycle
// - global enable masks all but power-fail
// - flags set regardless of enable
// - timer0/1, edge ext0/1 auto-cleared on call
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
module interrupt_priority_controller
  import irq_ctrl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // sources (pins asynchronous, peripheral events same clock)
  input  wire logic        ext0_n_i,
  input  wire logic        ext1_n_i,
  input  wire logic        ext2_i,
  input  wire logic        ext3_n_i,
  input  wire logic        ext4_i,
  input  wire logic        ext5_n_i,
  input  wire logic        power_fail_warn_level_i,
  input  wire logic        timer_zero_overflow_i,
  input  wire logic        timer_one_overflow_i,
  input  wire logic        timer_two_overflow_i,
  input  wire logic        uart0_rx_done_i,
  input  wire logic        uart0_tx_done_i,
  input  wire logic        uart1_rx_done_i,
  input  wire logic        uart1_tx_done_i,
  input  wire logic        wdog_event_i,
  input  wire logic        rtc_alarm_i,
  // cpu sequencer
  input  wire logic        instr_last_cycle_i,
  input  wire logic        instr_is_return_from_interrupt_i,
  input  wire logic        instr_writes_irq_reg_i,
  input  wire logic        in_stop_mode_i,
  output logic             forced_long_call_o,
  output logic      [15:0] call_vector_o,
  output logic             mcyc_tick_o,
  output logic             stop_wake_o,
  output logic      [15:0] uart_flags_o
);

  // -------------------------------------------------------------------------
  // machine cycle divider
  // -------------------------------------------------------------------------
  logic [1:0] div_q;
  wire        div_wrap = (div_q == 2'(CLKS_PER_MCYC - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) div_q <= 2'h0;
    else       div_q <= div_wrap ? 2'h0 : div_q + 2'h1;
  end

  // sample at first clock of cycle, poll at the last
  wire sample_en = (div_q == 2'h0);
  wire poll_en   = div_wrap;
  assign mcyc_tick_o = div_wrap;

  // -------------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------------
  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  wire  [6:0] pin_raw = {power_fail_warn_level_i, ~ext5_n_i, ext4_i, ~ext3_n_i, ext2_i, ~ext1_n_i, ~ext0_n_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_q <= 7'h00;
      pin_s2_q <= 7'h00;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  // per-machine-cycle pin sample, previous sample for pseudo edges
  logic [5:0] ext_smp_q;
  logic [5:0] ext_prev_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_smp_q  <= 6'h00;
      ext_prev_q <= 6'h00;
    end else if (sample_en) begin
      ext_smp_q  <= pin_s2_q[5:0];
      ext_prev_q <= ext_smp_q;
    end
  end
  wire [5:0] ext_edge = ext_smp_q & ~ext_prev_q & {6{sample_en}};

  // -------------------------------------------------------------------------
  // registers and bus decode
  // -------------------------------------------------------------------------
  logic [13:0] flag_q;
  logic [13:0] flag_d;
  logic [13:0] enable_q;
  logic [13:0] prio_q;
  logic [3:0]  cfg_q;
  logic [3:0]  uart_sub_q;
  logic [3:0]  uart_sub_d;
  logic        ack_q;

  wire req     = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr      = req & wb_we_i;
  wire wr_lo   = wr & wb_sel_i[0];
  wire wr_hi   = wr & wb_sel_i[1];
  wire sel_set = (wb_adr_i == OFS_FLAG_SET);
  wire sel_clr = (wb_adr_i == OFS_FLAG_CLR);
  wire sel_en  = (wb_adr_i == OFS_ENABLE);
  wire sel_pr  = (wb_adr_i == OFS_PRIORITY);
  wire sel_cfg = (wb_adr_i == OFS_CONFIG);
  wire sel_st  = (wb_adr_i == OFS_STATUS);

  wire [13:0] byte_mask = {{6{wr_hi}}, {8{wr_lo}}};
  wire [13:0] sw_set    = (sel_set ? wb_dat_i[13:0] & byte_mask : 14'h0000);
  wire [13:0] sw_clr    = (sel_clr ? wb_dat_i[13:0] & byte_mask : 14'h0000);
  // uart sub-flags live in bits 19:16 of the set/clear words
  wire [3:0]  sw_uset   = (sel_set & wr & wb_sel_i[2]) ? wb_dat_i[19:16] : 4'h0;
  wire [3:0]  sw_uclr   = (sel_clr & wr & wb_sel_i[2]) ? wb_dat_i[19:16] : 4'h0;

  // -------------------------------------------------------------------------
  // hardware events
  // -------------------------------------------------------------------------
  // only word-complete strobes set uart flags
  wire [3:0] uart_hw = {uart1_tx_done_i, uart1_rx_done_i, uart0_tx_done_i, uart0_rx_done_i};

  logic [13:0] hw_set;
  logic [13:0] auto_clr;
  logic        call_fire;
  logic [3:0]  win_idx;

  always_comb begin
    hw_set = 14'h0000;
    hw_set[SRC_TMR0]  = timer_zero_overflow_i;
    hw_set[SRC_TMR1]  = timer_one_overflow_i;
    hw_set[SRC_TMR2]  = timer_two_overflow_i;
    hw_set[SRC_EXT0]  = cfg_q[CFG_EXT0_EDGE] & ext_edge[0];
    hw_set[SRC_EXT1]  = cfg_q[CFG_EXT1_EDGE] & ext_edge[1];
    hw_set[SRC_EXT2]  = ext_edge[2];
    hw_set[SRC_EXT3]  = ext_edge[3];
    hw_set[SRC_EXT4]  = ext_edge[4];
    hw_set[SRC_EXT5]  = ext_edge[5];
    hw_set[SRC_WDOG]  = wdog_event_i;
    hw_set[SRC_RTC]   = rtc_alarm_i;
    auto_clr = 14'h0000;
    auto_clr[SRC_TMR0] = call_fire & (win_idx == 4'(SRC_TMR0));
    auto_clr[SRC_TMR1] = call_fire & (win_idx == 4'(SRC_TMR1));
    auto_clr[SRC_EXT0] = call_fire & (win_idx == 4'(SRC_EXT0)) & cfg_q[CFG_EXT0_EDGE];
    auto_clr[SRC_EXT1] = call_fire & (win_idx == 4'(SRC_EXT1)) & cfg_q[CFG_EXT1_EDGE];
  end

  always_comb begin
    flag_d = (flag_q & ~sw_clr & ~auto_clr) | sw_set | hw_set;
    flag_d[SRC_RTC] = (flag_q[SRC_RTC] & ~sw_clr[SRC_RTC]) | hw_set[SRC_RTC];
    uart_sub_d = (uart_sub_q & ~sw_uclr) | sw_uset | uart_hw;
    flag_d[SRC_UART0] = |uart_sub_d[1:0];
    flag_d[SRC_UART1] = |uart_sub_d[3:2];
    if (!cfg_q[CFG_EXT0_EDGE]) flag_d[SRC_EXT0] = ext_smp_q[0];
    if (!cfg_q[CFG_EXT1_EDGE]) flag_d[SRC_EXT1] = ext_smp_q[1];
    flag_d[SRC_PFAIL] = pin_s2_q[6];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q     <= 14'h0000;
      uart_sub_q <= 4'h0;
      enable_q   <= ENABLE_RST;
      prio_q     <= PRIORITY_RST;
      cfg_q      <= CONFIG_RST;
      ack_q      <= 1'b0;
    end else begin
      flag_q     <= flag_d;
      uart_sub_q <= uart_sub_d;
      ack_q      <= req;
      if (sel_en)  enable_q <= (enable_q & ~byte_mask) | (wb_dat_i[13:0] & byte_mask);
      if (sel_pr)  prio_q   <= (prio_q & ~byte_mask) | (wb_dat_i[13:0] & byte_mask);
      if (sel_cfg & wr_lo) cfg_q <= wb_dat_i[3:0];
    end
  end

  // -------------------------------------------------------------------------
  // sampling and arbitration
  // -------------------------------------------------------------------------
  logic [13:0] smp_q;
  always_ff @(posedge clk_i) begin
    if (rst_i)          smp_q <= 14'h0000;
    else if (sample_en) smp_q <= flag_q;
  end

  wire [13:0] live = smp_q & flag_q;

  // global enable masks all but power-fail
  logic [13:0] gate_en;
  always_comb begin
    gate_en = enable_q & {14{cfg_q[CFG_GLOBAL_EN]}};
    gate_en[SRC_PFAIL] = cfg_q[CFG_PFAIL_EN];
  end
  wire [13:0] pend = live & gate_en;

  logic [1:0] src_lvl [NUM_SRC];
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_lvl
    if (g == SRC_PFAIL) begin : g_top
      assign src_lvl[g] = 2'(LVL_TOP);
    end else begin : g_prog
      assign src_lvl[g] = prio_q[g] ? 2'(LVL_HIGH) : 2'(LVL_LOW);
    end
  end

  // service stack: one bit per level in progress
  logic [2:0] active_q;
  logic [2:0] active_d;
  logic [1:0] cur_lvl;
  always_comb begin
    cur_lvl = 2'(LVL_LOW);
    if (active_q[LVL_HIGH]) cur_lvl = 2'(LVL_HIGH);
    if (active_q[LVL_TOP])  cur_lvl = 2'(LVL_TOP);
  end

  logic       win_any;
  logic [1:0] win_lvl;
  always_comb begin
    win_any = 1'b0;
    win_lvl = 2'(LVL_LOW);
    win_idx = 4'h0;
    // lowest index wins ties; rtc last
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i] && (!win_any || src_lvl[i] >= win_lvl)) begin
        win_any = 1'b1;
        win_lvl = src_lvl[i];
        win_idx = 4'(i);
      end
    end
  end

  wire preempt_ok = (active_q == 3'h0) || (win_lvl > cur_lvl);

  // -------------------------------------------------------------------------
  // acknowledge sequencer
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_CALL
  } seq_e;

  seq_e       state_q;
  logic [1:0] call_cnt_q;
  logic [1:0] arm_lvl_q;

  // withheld by busy, midinstr, return_from_interrupt, register write
  // enables re-evaluated at call time, so new values apply
  wire blocked = !preempt_ok || !instr_last_cycle_i || instr_is_return_from_interrupt_i || instr_writes_irq_reg_i;
  assign call_fire = (state_q != ST_CALL) && poll_en && win_any && !blocked;

  always_comb begin
    active_d = active_q;
    if (instr_is_return_from_interrupt_i && instr_last_cycle_i && poll_en) begin
      // return ends highest level in progress
      if (active_q[LVL_TOP])       active_d[LVL_TOP]  = 1'b0;
      else if (active_q[LVL_HIGH]) active_d[LVL_HIGH] = 1'b0;
      else                         active_d[LVL_LOW]  = 1'b0;
    end
    if (call_fire) active_d[win_lvl] = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q       <= ST_IDLE;
      call_cnt_q    <= 2'h0;
      arm_lvl_q     <= 2'h0;
      active_q      <= 3'h0;
      call_vector_o <= 16'h0000;
    end else begin
      active_q <= active_d;
      case (state_q)
        // poll detected samples, call next cycle
        ST_IDLE, ST_ARMED: begin
          if (call_fire) begin
            state_q       <= ST_CALL;
            call_cnt_q    <= 2'h0;
            arm_lvl_q     <= win_lvl;
            call_vector_o <= VEC_BASE + VEC_STEP * 16'(win_idx);
          end else if (poll_en) begin
            state_q <= (win_any && preempt_ok) ? ST_ARMED : ST_IDLE;
          end
        end
        ST_CALL: if (poll_en) begin
          if (call_cnt_q == 2'(FORCED_LONG_CALL_MCYC - 1)) state_q <= ST_IDLE;
          call_cnt_q <= call_cnt_q + 2'h1;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign forced_long_call_o = (state_q == ST_CALL);
  // rtc alarm can wake from stop
  assign stop_wake_o = in_stop_mode_i & flag_q[SRC_RTC] & enable_q[SRC_RTC];
  assign uart_flags_o = {12'h000, uart_sub_q};

  // -------------------------------------------------------------------------
  // read back
  // -------------------------------------------------------------------------
  wire [31:0] rd_mux =
      sel_set ? {12'h000, uart_sub_q, 2'h0, flag_q} :
      sel_en  ? {18'h00000, enable_q} :
      sel_pr  ? {18'h00000, prio_q} :
      sel_cfg ? {28'h0000000, cfg_q} :
      sel_st  ? {20'h00000, win_idx, forced_long_call_o, active_q, 1'b0, arm_lvl_q, 1'b0} :
      32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i)    wb_dat_o <= 32'h00000000;
    else if (req) wb_dat_o <= rd_mux;
  end
  assign wb_ack_o = ack_q;

endmodule : interrupt_priority_controller

// ===== irq_ctrl_chk.sv
`timescale 1ns/10ps
module irq_ctrl_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        instr_last_cycle_i,
  input wire logic        instr_is_return_from_interrupt_i,
  input wire logic        instr_writes_irq_reg_i,
  input wire logic        in_stop_mode_i,
  input wire logic        forced_long_call_o,
  input wire logic [15:0] call_vector_o,
  input wire logic        mcyc_tick_o,
  input wire logic        stop_wake_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // -----------------------------
  // call length
  // -----------------------------
  logic [4:0] len_q;
  logic [4:0] len_d;
  assign len_d = forced_long_call_o ? len_q + 5'h01 : 5'h00;
  always_ff @(posedge clk_i) begin
    if (rst_i) len_q <= 5'h00;
    else len_q <= len_d;
  end
  AST_TICK: assert property (mcyc_tick_o |=> !mcyc_tick_o [*3] ##1 mcyc_tick_o)
    else $error("tick spacing");
  AST_LEN: assert property ($fell(forced_long_call_o) |-> len_q == 5'h10)
    else $error("call length");
  AST_ONTICK: assert property ($rose(forced_long_call_o) |-> $past(mcyc_tick_o))
    else $error("call off poll");
  AST_LAST: assert property ($rose(forced_long_call_o) |-> $past(instr_last_cycle_i))
    else $error("call mid instruction");
  AST_NOBLK: assert property ($rose(forced_long_call_o) |->
    !$past(instr_is_return_from_interrupt_i) && !$past(instr_writes_irq_reg_i))
    else $error("call during blocked instruction");
  AST_VEC: assert property (forced_long_call_o |-> call_vector_o[2:0] == 3'h3 && call_vector_o <= 16'h006B)
    else $error("bad vector");
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing");
  AST_WAKE: assert property (stop_wake_o |-> in_stop_mode_i)
    else $error("wake outside stop");
  cover property ($rose(forced_long_call_o));
  cover property (stop_wake_o);
  cover property (instr_is_return_from_interrupt_i && mcyc_tick_o);
endmodule : irq_ctrl_chk

bind interrupt_priority_controller irq_ctrl_chk CHK (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .instr_last_cycle_i, .instr_is_return_from_interrupt_i, .instr_writes_irq_reg_i, .in_stop_mode_i,
  .forced_long_call_o, .call_vector_o, .mcyc_tick_o, .stop_wake_o);

// ===== cpu_seq_model.sv
`timescale 1ns/10ps
module cpu_seq_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic tick_i,
  input  wire logic call_i,
  input  wire logic stall_i,
  input  wire logic return_from_interrupt_i,
  input  wire logic wr_i,
  output logic      last_o,
  output logic      return_from_interrupt_o,
  output logic      wr_o
);
  assign last_o = !stall_i && !call_i;
  // instruction kind only changes at a boundary
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      return_from_interrupt_o <= 1'b0;
      wr_o   <= 1'b0;
    end else if (tick_i && last_o) begin
      return_from_interrupt_o <= return_from_interrupt_i;
      wr_o   <= wr_i;
    end
  end
endmodule : cpu_seq_model

// ===== test_interrupt_priority_controller.sv
`timescale 1ns/10ps
module test_interrupt_priority_controller
  import irq_ctrl_pkg::*;
;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, stall, return_from_interrupt_cmd, wr_cmd;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic [15:0] src, call_vector_o, uart_flags_o;
  logic        ext0_n_i, ext1_n_i, ext2_i, ext3_n_i, ext4_i, ext5_n_i, power_fail_warn_level_i;
  logic        timer_zero_overflow_i, timer_one_overflow_i, timer_two_overflow_i, wdog_event_i;
  logic        uart0_rx_done_i, uart0_tx_done_i, uart1_rx_done_i, uart1_tx_done_i, rtc_alarm_i;
  logic        instr_last_cycle_i, instr_is_return_from_interrupt_i, instr_writes_irq_reg_i, in_stop_mode_i;
  logic        forced_long_call_o, mcyc_tick_o, stop_wake_o;
  int          err_total, checks_done, wait_n;
  assign power_fail_warn_level_i = src[0];
  assign ext0_n_i = !src[1];
  assign timer_zero_overflow_i = src[2];
  assign ext1_n_i = !src[3];
  assign timer_one_overflow_i = src[4];
  assign uart0_rx_done_i = src[5];
  assign timer_two_overflow_i = src[6];
  assign uart1_rx_done_i = src[7];
  assign ext2_i = src[8];
  assign ext3_n_i = !src[9];
  assign ext4_i = src[10];
  assign ext5_n_i = !src[11];
  assign wdog_event_i = src[12];
  assign rtc_alarm_i = src[13];
  assign uart0_tx_done_i = src[14];
  assign uart1_tx_done_i = src[15];
  interrupt_priority_controller DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext0_n_i, .ext1_n_i, .ext2_i, .ext3_n_i, .ext4_i, .ext5_n_i,
    .power_fail_warn_level_i, .timer_zero_overflow_i, .timer_one_overflow_i, .timer_two_overflow_i,
    .uart0_rx_done_i, .uart0_tx_done_i, .uart1_rx_done_i, .uart1_tx_done_i, .wdog_event_i, .rtc_alarm_i,
    .instr_last_cycle_i, .instr_is_return_from_interrupt_i, .instr_writes_irq_reg_i, .in_stop_mode_i,
    .forced_long_call_o, .call_vector_o, .mcyc_tick_o, .stop_wake_o, .uart_flags_o);
  cpu_seq_model SEQ (.clk_i, .rst_i, .tick_i(mcyc_tick_o), .call_i(forced_long_call_o), .stall_i(stall),
    .return_from_interrupt_i(return_from_interrupt_cmd), .wr_i(wr_cmd), .last_o(instr_last_cycle_i), .return_from_interrupt_o(instr_is_return_from_interrupt_i),
    .wr_o(instr_writes_irq_reg_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // -----------------------------
  // shared tasks
  // -----------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chk("ack", 32'h1, 32'(wb_ack_o));
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // zero means no call may come within 20 machine cycles
  task automatic exp_call(input logic [15:0] v);
    int n = 0;
    while (forced_long_call_o !== 1'b1 && n < 80) begin
      @(posedge clk_i);
      n++;
    end
    wait_n = n;
    chk("vector", 32'(v), 32'(forced_long_call_o ? call_vector_o : 16'h0000));
    while (forced_long_call_o === 1'b1) @(posedge clk_i);
  endtask : exp_call
  task automatic do_return_from_interrupt();
    int n = 0;
    return_from_interrupt_cmd <= 1'b1;
    while (instr_is_return_from_interrupt_i !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk("return_from_interrupt seen", 32'h1, 32'(instr_is_return_from_interrupt_i));
    return_from_interrupt_cmd <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : do_return_from_interrupt
  task automatic end_sim();
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  // -----------------------------
  // scenarios
  // -----------------------------
  task automatic t_reset();
    wb(1'b0, OFS_PRIORITY, 32'h0);
    chk("priority", 32'(PRIORITY_RST), rdat);
    wb(1'b1, 8'h3C, 32'hFFFFFFFF);
    wb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", 32'h0, rdat);
  endtask : t_reset
  task automatic t_flags();
    int b;
    for (int i = 0; i < 16; i++) begin
      b = (i < 14) ? i : ((i == 14) ? 5 : 7);
      src <= 16'h0001 << i;
      @(posedge clk_i);
      src <= src & 16'h0F0B;
      repeat (12) @(posedge clk_i);
      wb(1'b0, OFS_FLAG_SET, 32'h0);
      chk("flag set", 32'h1 << b, {18'h0, rdat[13:0]});
      if (i == 5) chk("uart rx", 32'h1, 32'(uart_flags_o));
      if (i == 14) chk("uart tx", 32'h2, 32'(uart_flags_o));
      src <= 16'h0000;
      repeat (12) @(posedge clk_i);
      wb(1'b1, OFS_FLAG_CLR, 32'h000F0000 | (32'h1 << b));
      wb(1'b0, OFS_FLAG_SET, 32'h0);
      chk("flag clear", 32'h0, {18'h0, rdat[13:0]});
    end
  endtask : t_flags
  task automatic t_tie();
    wb(1'b1, OFS_CONFIG, 32'h1);
    wb(1'b1, OFS_ENABLE, 32'h14);
    wb(1'b1, OFS_FLAG_SET, 32'h14);
    exp_call(16'h0013);
    chk("fast response", 32'h1, 32'(wait_n + 2 <= 2 * CLKS_PER_MCYC));
    wb(1'b0, OFS_FLAG_SET, 32'h0);
    chk("auto clear", 32'h10, {18'h0, rdat[13:0]});
    do_return_from_interrupt();
    exp_call(16'h0023);
    do_return_from_interrupt();
  endtask : t_tie
  task automatic t_block();
    wb(1'b1, OFS_ENABLE, 32'h40);
    stall <= 1'b1;
    wb(1'b1, OFS_FLAG_SET, 32'h40);
    exp_call(16'h0000);
    wb(1'b1, OFS_FLAG_CLR, 32'h40);
    stall <= 1'b0;
    exp_call(16'h0000);
    wr_cmd <= 1'b1;
    repeat (8) @(posedge clk_i);
    wb(1'b1, OFS_FLAG_SET, 32'h40);
    exp_call(16'h0000);
    wr_cmd <= 1'b0;
    exp_call(16'h0033);
    wb(1'b1, OFS_FLAG_CLR, 32'h40);
    do_return_from_interrupt();
  endtask : t_block
  task automatic t_preempt();
    wb(1'b1, OFS_PRIORITY, 32'h20);
    wb(1'b1, OFS_ENABLE, 32'h70);
    wb(1'b1, OFS_FLAG_SET, 32'h40);
    exp_call(16'h0033);
    wb(1'b1, OFS_FLAG_CLR, 32'h40);
    wb(1'b1, OFS_FLAG_SET, 32'h10);
    exp_call(16'h0000);
    wb(1'b1, OFS_FLAG_SET, 32'h00010020);
    exp_call(16'h002B);
    chk("uart kept", 32'h1, 32'(uart_flags_o));
    wb(1'b1, OFS_FLAG_CLR, 32'h000F0020);
    do_return_from_interrupt();
    exp_call(16'h0000);
    do_return_from_interrupt();
    exp_call(16'h0023);
    do_return_from_interrupt();
    wb(1'b1, OFS_PRIORITY, 32'h0);
  endtask : t_preempt
  task automatic t_pfail();
    wb(1'b1, OFS_CONFIG, 32'h2);
    wb(1'b1, OFS_FLAG_SET, 32'h40);
    src <= 16'h0001;
    exp_call(16'h0003);
    chk("worst response", 32'h1, 32'(wait_n < MAX_RESP_MCYC * CLKS_PER_MCYC));
    src <= 16'h0000;
    repeat (16) @(posedge clk_i);
    wb(1'b0, OFS_FLAG_SET, 32'h0);
    chk("pfail flag", 32'h40, {18'h0, rdat[13:0]});
    do_return_from_interrupt();
    exp_call(16'h0000);
    wb(1'b1, OFS_FLAG_CLR, 32'h40);
  endtask : t_pfail
  task automatic t_stop();
    wb(1'b1, OFS_ENABLE, 32'h2000);
    in_stop_mode_i <= 1'b1;
    wb(1'b1, OFS_FLAG_SET, 32'h2000);
    chk("rtc soft set", 32'h0, 32'(stop_wake_o));
    src <= 16'h2000;
    @(posedge clk_i);
    src <= 16'h0000;
    repeat (12) @(posedge clk_i);
    chk("wake", 32'h1, 32'(stop_wake_o));
    in_stop_mode_i <= 1'b0;
    wb(1'b1, OFS_FLAG_CLR, 32'h2000);
  endtask : t_stop
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    end_sim();
  end
  initial begin
    err_total = 0;
    checks_done = 0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, stall, return_from_interrupt_cmd, wr_cmd, in_stop_mode_i} = 7'h00;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    src = 16'h0000;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_flags();
    t_tie();
    t_block();
    t_preempt();
    t_pfail();
    t_stop();
    end_sim();
  end
endmodule : test_interrupt_priority_controller
